// File: shared/sram_clock_pkg.sv
// constants for the host-side port controller of a clock-mapped static ram
// assumes a 250 MHz controller clock and an asynchronous byte-wide device
package sram_clock_pkg;
  localparam int          CLK_PERIOD_PS    = 4000;
  localparam int          ADDR_W           = 15;
  localparam int          DATA_W           = 8;
  // clock byte map
  localparam logic [14:0] CLOCK_CTRL_ADDR  = 15'h7FF8;
  localparam logic [14:0] CLOCK_SEC_ADDR   = 15'h7FF9;
  localparam logic [14:0] CLOCK_YEAR_ADDR  = 15'h7FFF;
  localparam int          CTRL_SET_BIT     = 7;
  localparam int          CTRL_HALT_BIT    = 6;
  localparam int          CTRL_SIGN_BIT    = 5;
  localparam logic [7:0]  CTRL_CAL_MASK    = 8'h3F;
  // timing, ns as printed
  localparam int          READ_CYCLE_NS    = 70;
  localparam int          INDEX_TO_OUTPUT_DELAY_NS = 70;
  localparam int          OE_ACCESS_NS     = 35;
  localparam int          OUTPUT_HIZ_NS    = 25;
  localparam int          WRITE_PULSE_NS   = 50;
  localparam int          DATA_SETUP_NS    = 30;
  localparam int          DATA_HOLD_NS     = 5;
  localparam int          WRITE_CYCLE_NS   = 70;
  // minimum times round up to whole cycles
  localparam int          READ_CYC   = (INDEX_TO_OUTPUT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          HIZ_CYC    = (OUTPUT_HIZ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          WPULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          HOLD_CYC   = (DATA_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          RECOV_CYC  = ((WRITE_CYCLE_NS - WRITE_PULSE_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          CNT_W      = 5;
endpackage

// File: src/pin_sync.sv
// three-flop synchroniser for a pin level; change accepted when stages two and three agree
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ps
module pin_sync #(
  parameter int          W     = 8,
  parameter logic [W-1:0] INIT = '0
) (
  // clock
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  // level
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1, s2, s3, next_out;

  always_comb begin
    next_out = sync_out;
    if (s2 == s3) begin
      next_out = s3;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1       <= INIT;
      s2       <= INIT;
      s3       <= INIT;
      sync_out <= INIT;
    end else if (clk_en) begin
      s1       <= async_in;
      s2       <= s1;
      s3       <= s2;
      sync_out <= next_out;
    end
  end
endmodule

// File: src/clock_sram_host.sv
// host controller driving the strobes, index and byte lines of a clock-mapped static ram
// assumes the device is a plain asynchronous byte-wide part; data lines are resolved by the bench
`timescale 1ns/1ps

module clock_sram_host #(
  parameter int ADDR_W = sram_clock_pkg::ADDR_W,
  parameter int DATA_W = sram_clock_pkg::DATA_W
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  // user request
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_index,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata,
  // device pins
  output logic                   chip_select_n,
  output logic                   output_enable_n,
  output logic                   write_strobe_n,
  output logic      [ADDR_W-1:0] byte_index_lines,
  input  wire logic [DATA_W-1:0] byte_lines_in,
  output logic      [DATA_W-1:0] byte_lines_out,
  output logic                   byte_lines_oe_n
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RDACC = 3'b001,
    ST_RDCAP = 3'b011,
    ST_WRPUL = 3'b010,
    ST_WRHLD = 3'b110,
    ST_RECOV = 3'b111,
    ST_RDSYN = 3'b101
  } state_e;

  localparam logic [4:0] READ_N  = 5'(sram_clock_pkg::READ_CYC);
  localparam logic [4:0] WPUL_N  = 5'(sram_clock_pkg::WPULSE_CYC);
  localparam logic [4:0] HOLD_N  = 5'(sram_clock_pkg::HOLD_CYC);
  localparam logic [4:0] RECOV_N = 5'(sram_clock_pkg::RECOV_CYC);
  localparam logic [4:0] HIZ_N   = 5'(sram_clock_pkg::HIZ_CYC);
  localparam logic [4:0] SYNC_N  = 5'h03;

  state_e            state, next_state;
  logic [4:0]        cnt, next_cnt;
  logic              cs_n, next_cs_n, oe_n, next_oe_n, we_n, next_we_n, doe_n, next_doe_n;
  logic [ADDR_W-1:0] idx, next_idx;
  logic [DATA_W-1:0] wdat, next_wdat, rdat, next_rdat;
  logic              rvld, next_rvld;
  logic [DATA_W-1:0] din_sync;

  pin_sync #(.W(DATA_W), .INIT('0)) u_din_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .async_in (byte_lines_in),
    .sync_out (din_sync)
  );

  assign req_ready        = (state == ST_IDLE);
  assign chip_select_n    = cs_n;
  assign output_enable_n  = oe_n;
  assign write_strobe_n   = we_n;
  assign byte_index_lines = idx;
  assign byte_lines_out   = wdat;
  assign byte_lines_oe_n  = doe_n;
  assign rsp_valid        = rvld;
  assign rsp_rdata        = rdat;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_cs_n  = cs_n;
    next_oe_n  = oe_n;
    next_we_n  = we_n;
    next_doe_n = doe_n;
    next_idx   = idx;
    next_wdat  = wdat;
    next_rdat  = rdat;
    next_rvld  = 1'b0;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          // every index, clock bytes included, takes the same cycle
          next_idx  = req_index;
          next_cs_n = 1'b0;
          next_cnt  = 5'h00;
          if (req_write) begin
            next_wdat  = req_wdata;
            next_oe_n  = 1'b1;
            next_we_n  = 1'b0;
            next_doe_n = 1'b0;
            next_state = ST_WRPUL;
          end else begin
            next_oe_n  = 1'b0;
            next_we_n  = 1'b1;
            next_doe_n = 1'b1;
            next_state = ST_RDACC;
          end
        end
      end
      ST_RDACC: begin
        // wait the longest access delay before trusting the lines
        next_cnt = cnt + 5'h01;
        if (cnt + 5'h01 >= READ_N) begin
          next_cnt   = 5'h00;
          next_state = ST_RDSYN;
        end
      end
      ST_RDSYN: begin
        // cover the synchroniser latency so the captured byte is settled
        next_cnt = cnt + 5'h01;
        if (cnt + 5'h01 >= SYNC_N) begin
          next_state = ST_RDCAP;
        end
      end
      ST_RDCAP: begin
        next_rdat  = din_sync;
        next_rvld  = 1'b1;
        next_cs_n  = 1'b1;
        next_oe_n  = 1'b1;
        next_cnt   = 5'h00;
        next_state = ST_RECOV;
      end
      ST_WRPUL: begin
        // pulse also covers data set-up, index held fixed
        next_cnt = cnt + 5'h01;
        if (cnt + 5'h01 >= WPUL_N) begin
          next_we_n  = 1'b1;
          next_cs_n  = 1'b1;
          next_cnt   = 5'h00;
          next_state = ST_WRHLD;
        end
      end
      ST_WRHLD: begin
        next_cnt = cnt + 5'h01;
        if (cnt + 5'h01 >= HOLD_N) begin
          next_doe_n = 1'b1;
          next_cnt   = 5'h00;
          next_state = ST_RECOV;
        end
      end
      ST_RECOV: begin
        // strobes stay high for recovery and to let device outputs float
        next_cnt = cnt + 5'h01;
        if (cnt + 5'h01 >= ((RECOV_N > HIZ_N) ? RECOV_N : HIZ_N)) begin
          next_cnt   = 5'h00;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cs_n  = 1'b1;
        next_oe_n  = 1'b1;
        next_we_n  = 1'b1;
        next_doe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cnt   <= 5'h00;
      cs_n  <= 1'b1;
      oe_n  <= 1'b1;
      we_n  <= 1'b1;
      doe_n <= 1'b1;
      idx   <= '0;
      wdat  <= '0;
      rdat  <= '0;
      rvld  <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      cnt   <= next_cnt;
      cs_n  <= next_cs_n;
      oe_n  <= next_oe_n;
      we_n  <= next_we_n;
      doe_n <= next_doe_n;
      idx   <= next_idx;
      wdat  <= next_wdat;
      rdat  <= next_rdat;
      rvld  <= next_rvld;
    end
  end
endmodule

// File: tb/clock_sram_host_properties.sv
// assertions on the host controller pins
// assumes clk_en stays high through every transfer
`timescale 1ns/1ps
module clock_sram_host_properties (
  input wire logic        sys_clk, resetn, clk_en, req_valid, req_write, req_ready, rsp_valid,
  input wire logic        chip_select_n, output_enable_n, write_strobe_n, byte_lines_oe_n,
  input wire logic [14:0] byte_index_lines,
  input wire logic [7:0]  byte_lines_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire take_rd = clk_en && req_valid && req_ready && !req_write;
  index_hold_a: assert property (!write_strobe_n |=> write_strobe_n || $stable(byte_index_lines))
    else $error("index moved");
  data_setup_a: assert property ($rose(write_strobe_n) |-> $past(byte_lines_out, 8) == byte_lines_out)
    else $error("setup short");
  data_hold_a: assert property ($rose(write_strobe_n) |-> (!byte_lines_oe_n && $stable(byte_lines_out))[*2])
    else $error("hold short");
  no_fight_a: assert property (!write_strobe_n || !byte_lines_oe_n |-> output_enable_n)
    else $error("oe in write");
  write_recovery_a: assert property ($rose(write_strobe_n) |-> write_strobe_n[*5])
    else $error("recovery short");
  write_pulse_a: assert property ($fell(write_strobe_n) |-> (!chip_select_n && !write_strobe_n)[*8] ##1 (!write_strobe_n)[*5])
    else $error("pulse short");
  read_pins_a: assert property (take_rd |-> ##[1:2] (!chip_select_n && !output_enable_n && write_strobe_n))
    else $error("read pins");
  read_answer_a: assert property (take_rd |-> ##[20:26] rsp_valid)
    else $error("no answer");
endmodule
bind clock_sram_host clock_sram_host_properties clock_sram_host_properties_i (.*);

// File: tb/sram_clock_device.sv
// behavioural clock ram: byte array, clock bytes, power fail
// assumes the bench resolves the shared byte lines
`timescale 1ns/1ps
module sram_clock_device #(parameter int TICK_NS = 1000) (
  input  wire logic        chip_select_n, output_enable_n, write_strobe_n, supply_fail,
  input  wire logic [14:0] byte_index_lines,
  input  wire logic [7:0]  byte_lines,
  output logic      [7:0]  dev_data,
  output logic             dev_drive
);
  logic [7:0] mem [0:32767];
  logic [7:0] tc [0:6];
  realtime    t_acc = 0, t_tick = 0;
  // powers up halted so the early tests own the clock bytes
  initial begin
    mem[15'h7FF8] = 8'h40;
    for (int k = 0; k < 7; k++) tc[k] = 8'h00;
  end
  function automatic logic [7:0] bump(input logic [7:0] v, input logic [7:0] top, input logic [7:0] low);
    return v == top ? low : v[3:0] == 4'h9 ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction
  // leap test on the two bcd year digits, good until 2100
  function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
    if (m == 8'h02) return ((y[7:4] * 10 + y[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
    return (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) ? 8'h30 : 8'h31;
  endfunction
  // stricter than needed: output enable also waits the full access
  always @(byte_index_lines or negedge chip_select_n or negedge output_enable_n) t_acc = $realtime;
  always @(posedge (chip_select_n | write_strobe_n)) begin
    if (!supply_fail && $realtime > 0) begin
      if (byte_index_lines == 15'h7FF8 && mem[15'h7FF8][7] && !byte_lines[7]) begin
        for (int k = 0; k < 7; k++) tc[k] = mem[15'h7FF9 + k];
        t_tick = $realtime;
      end
      mem[byte_index_lines] = byte_lines;
    end
  end
  always #1 begin
    if ($realtime - t_tick >= TICK_NS) begin
      t_tick = $realtime;
      tc[0] = bump(tc[0], 8'h59, 8'h00);
      if (tc[0] == 8'h00) tc[1] = bump(tc[1], 8'h59, 8'h00);
      if (tc[0] == 8'h00 && tc[1] == 8'h00) begin
        tc[2] = bump(tc[2], 8'h23, 8'h00);
        if (tc[2] == 8'h00) begin
          tc[3] = bump(tc[3], 8'h07, 8'h01);
          tc[4] = bump(tc[4], month_end(tc[5], tc[6]), 8'h01);
          if (tc[4] == 8'h01) begin
            tc[5] = bump(tc[5], 8'h12, 8'h01);
            if (tc[5] == 8'h01) tc[6] = bump(tc[6], 8'h99, 8'h00);
          end
        end
      end
      if (!mem[15'h7FF8][6] && !mem[15'h7FF8][7]) begin
        for (int k = 0; k < 7; k++) mem[15'h7FF9 + k] = tc[k];
      end
    end
    dev_drive = !supply_fail && !chip_select_n && !output_enable_n && write_strobe_n;
    dev_data = $realtime >= t_acc + 70 ? mem[byte_index_lines] : 8'hXX;
  end
endmodule

// File: tb/clock_sram_host_test.sv
// bench: host controller against a behavioural clock ram
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module clock_sram_host_test;
  logic        sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, supply_fail = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [14:0] req_index = 15'h0000, byte_index_lines;
  logic [7:0]  req_wdata = 8'h00, last = 8'h00, rsp_rdata, byte_lines_out, byte_lines, dev_data;
  logic        req_ready, rsp_valid, chip_select_n, output_enable_n, write_strobe_n, byte_lines_oe_n, dev_drive;
  int          err_total = 0, checked = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  // a released line shows the inverse of its last level
  assign byte_lines = !byte_lines_oe_n ? byte_lines_out : dev_drive ? dev_data : ~last;
  always @(posedge sys_clk) begin
    if (!byte_lines_oe_n || dev_drive) last <= byte_lines;
    if (!byte_lines_oe_n && dev_drive) fail("both drive");
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail("timeout");
      end_of_test;
    end
  end
  clock_sram_host clock_sram_host_i (.*, .byte_lines_in(byte_lines));
  sram_clock_device sram_clock_device_i (.*);
  task automatic fail(input string m);
    err_total++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic req(input logic w, input logic [14:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    {req_valid, req_write, req_index, req_wdata} <= {1'b1, w, i, d};
    @(negedge sys_clk);
    while (req_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask
  task automatic rd(input logic [14:0] i, input logic [7:0] e);
    req(1'b0, i, 8'h00);
    @(negedge sys_clk);
    while (rsp_valid !== 1'b1) @(negedge sys_clk);
    checked++;
    if (rsp_rdata !== e) fail("read data");
  endtask
  task automatic end_of_test;
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    req(1'b1, 15'h0000, 8'h5A);
    req(1'b1, 15'h7FFF, 8'hA5);
    req(1'b1, 15'h7FF7, 8'hC3);
    rd(15'h0000, 8'h5A);
    rd(15'h7FFF, 8'hA5);
    rd(15'h7FF7, 8'hC3);
    req(1'b1, 15'h7FF8, 8'h80);
    req(1'b1, 15'h7FF9, 8'h59);
    req(1'b1, 15'h7FFA, 8'h59);
    req(1'b1, 15'h7FFB, 8'h23);
    req(1'b1, 15'h7FFD, 8'h28);
    req(1'b1, 15'h7FFE, 8'h02);
    req(1'b1, 15'h7FFF, 8'h24);
    req(1'b1, 15'h7FF8, 8'h00);
    repeat (300) @(posedge sys_clk);
    req(1'b1, 15'h7FF8, 8'h40);
    rd(15'h7FF9, 8'h00);
    rd(15'h7FFB, 8'h00);
    rd(15'h7FFD, 8'h29);
    rd(15'h7FFE, 8'h02);
    repeat (600) @(posedge sys_clk);
    rd(15'h7FF9, 8'h00);
    rd(15'h7FF8, 8'h40);
    @(posedge sys_clk);
    supply_fail <= 1'b1;
    req(1'b1, 15'h0000, 8'h22);
    repeat (25) @(posedge sys_clk);
    supply_fail <= 1'b0;
    rd(15'h0000, 8'h5A);
    // a controller frozen in recovery must not take a request
    @(posedge sys_clk);
    {clk_en, req_valid, req_write, req_index} <= {1'b0, 1'b1, 1'b0, 15'h0000};
    repeat (12) @(negedge sys_clk);
    checked++;
    if (chip_select_n !== 1'b1) fail("frozen take");
    @(posedge sys_clk);
    {clk_en, req_valid} <= 2'b10;
    req(1'b1, 15'h0000, 8'h33);
    rd(15'h0000, 8'h33);
    end_of_test;
  end
endmodule
